/* rtl/twi_pkg.sv */
// Purpose: shared constants and types of the two-wire bus master
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes: every offset, field position and reset value lives here
package twi_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_IADR = 8'h0C;
	localparam logic [7:0] OFS_WAVE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_IER = 8'h24;
	localparam logic [7:0] OFS_IDR = 8'h28;
	localparam logic [7:0] OFS_IMR = 8'h2C;
	localparam logic [7:0] OFS_RHR = 8'h30;
	localparam logic [7:0] OFS_THR = 8'h34;
	// Command bits
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_MASTER_ENABLE_CMD = 2;
	localparam int CMD_MASTER_DISABLE_CMD = 3;
	localparam int CMD_SOFTWARE_RESET_CMD = 7;
	// Mode fields
	localparam int MODE_ASZ_LSB = 8;
	localparam int MODE_READ_BIT = 12;
	localparam int MODE_DEVICE_ADDRESS_FIELD_LSB = 16;
	localparam logic [31:0] MODE_MASK = 32'h007F_1300;
	// Waveform fields
	localparam int WAVE_LOW_LSB = 0;
	localparam int WAVE_HIGH_LSB = 8;
	localparam int WAVE_EXP_LSB = 16;
	localparam logic [31:0] WAVE_MASK = 32'h0007_FFFF;
	localparam logic [31:0] IADR_MASK = 32'h00FF_FFFF;
	// Status bits
	localparam int ST_TXCOMP = 0;
	localparam int ST_RECEIVE_READY_FLAG = 1;
	localparam int ST_TRANSMIT_READY_FLAG = 2;
	localparam int ST_OVRE = 6;
	localparam int ST_UNRE = 7;
	localparam int ST_NOT_ACK_STATUS = 8;
	localparam int ST_W = 9;
	// Values after reset
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [31:0] IADR_RESET = 32'h0000_0000;
	localparam logic [31:0] WAVE_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0008;
	localparam logic [31:0] IMR_RESET = 32'h0000_0000;
	localparam logic [7:0] RHR_RESET = 8'h00;
	localparam logic [7:0] THR_RESET = 8'h00;
	// Clock waveform timing: period = (divider << exponent) + 3 cycles
	localparam int TIMER_W = 16;
	localparam logic [15:0] TIMER_ADD = 16'h0003;
	localparam logic [1:0] SYNC_GRACE = 2'h2;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
	// Engine states
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_START = 5'h02,
		S_BITS = 5'h04,
		S_RELEASE = 5'h08,
		S_STOP = 5'h10
	} state_t;
	// Kind of byte on the wire
	typedef enum logic [3:0] {
		K_DEV = 4'h1,
		K_IAD = 4'h2,
		K_TX = 4'h4,
		K_RX = 4'h8
	} kind_t;
endpackage : twi_pkg

/* rtl/twi_sync2.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: the first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module twi_sync2 #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1;

	generate
		if (W < 1) begin : g_bad_width
			$error("twi_sync2 needs W of at least one");
		end
	endgenerate

	// Idle bus reads high, so reset to ones
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage1 <= '1;
			dout <= '1;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule : twi_sync2
`default_nettype wire

/* rtl/twi_period_timer.sv */
// Purpose: times one serial clock phase
// Assumes: load starts a period; run pauses it while the line is held
// Notes: period is (divider << exponent) + 3 running cycles
`timescale 1ns/1ps
`default_nettype none
module twi_period_timer
	import twi_pkg::*;
#(
	parameter int CW = TIMER_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic load,
	input wire logic run,
	input wire logic [7:0] divider,
	input wire logic [2:0] exponent,
	// End of period, one cycle
	output logic done
);
	logic [CW-1:0] cnt;
	logic [CW-1:0] target;
	logic busy;

	generate
		if (CW != TIMER_W) begin : g_bad_width
			$error("twi_period_timer counter width must match TIMER_W");
		end
	endgenerate

	assign target = ({8'h00, divider} << exponent) + TIMER_ADD;
	assign done = busy && run && (cnt == target - 16'h0001);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			busy <= 1'b0;
			cnt <= '0;
		end else if (load) begin
			busy <= 1'b1;
			cnt <= '0;
		end else if (done) begin
			busy <= 1'b0;
		end else if (busy && run) begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule : twi_period_timer
`default_nettype wire

/* rtl/two_wire_bus_master.sv */
// Purpose: master-only two-wire bus controller with register port
// Assumes: open-drain pads outside; 25 MHz clk; inputs pass two flops
// Notes: slave clock stretching pauses the high-phase timer
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_master
	import twi_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire bus_req_t bus,
	output logic [31:0] rdata,
	// Interrupt
	output logic irq,
	// Serial clock pin
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe_n,
	// Serial data pin
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_n
);
	state_t state;
	kind_t kind;
	logic swrstPulse, rstAll;
	logic [31:0] modeReg, iadrReg, waveReg;
	logic [ST_W-1:0] mask, statusVec;
	logic [7:0] thr, rhr, shift;
	logic thrFull, master_enable_cmd, disablePend, stopReq, restarted;
	logic txComp, transmit_ready_flag, receive_ready_flag, ovre, not_ack_status;
	logic pullScl, pullSda, hi, tmrDone, tmrLoad, tmrRun;
	logic [1:0] step, idx, nextIdx, relCnt, asz;
	logic [3:0] bitCnt;
	logic [1:0] pinSync;
	logic sclSync, sdaSync, rdDir;
	logic [6:0] device_address_field;
	logic cmdWr, thrWr, srRd, rhrRd, go, msenEv;
	logic bitEnd, ackEnd, nackEv, rxLand, stopDone, bitPull;
	logic goStop, goRestart, goIad, goTx, goRx;

	// Decoded strobes
	assign cmdWr = bus.wr && bus.addr == OFS_CMD;
	assign thrWr = bus.wr && bus.addr == OFS_THR;
	assign srRd = bus.rd && bus.addr == OFS_STATUS;
	assign rhrRd = bus.rd && bus.addr == OFS_RHR;
	assign msenEv = cmdWr && bus.wdata[CMD_MASTER_ENABLE_CMD] && !bus.wdata[CMD_MASTER_DISABLE_CMD];
	assign rstAll = !reset_n || swrstPulse;
	assign device_address_field = modeReg[MODE_DEVICE_ADDRESS_FIELD_LSB +: 7];
	assign rdDir = modeReg[MODE_READ_BIT];
	assign asz = modeReg[MODE_ASZ_LSB +: 2];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			swrstPulse <= 1'b0;
		end else begin
			swrstPulse <= cmdWr && bus.wdata[CMD_SOFTWARE_RESET_CMD];
		end
	end

	// Pin inputs cross into clk before use
	twi_sync2 #(.W(2)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.din({sclIn, sdaIn}),
		.dout(pinSync)
	);
	assign sclSync = pinSync[1];
	assign sdaSync = pinSync[0];

	// Grace covers sync latency so unstretched phases stay exact
	always_ff @(posedge clk) begin
		if (rstAll || pullScl) begin
			relCnt <= 2'h0;
		end else if (relCnt != 2'h3) begin
			relCnt <= relCnt + 2'h1;
		end
	end
	assign tmrRun = pullScl || sclSync || relCnt < SYNC_GRACE;
	assign tmrLoad = (state == S_IDLE && go) ||
		(tmrDone && !(state == S_STOP && step == 2'h2));

	// phase timer driven by waveform setup
	twi_period_timer u_timer (
		.clk(clk),
		.reset_n(!rstAll),
		.load(tmrLoad),
		.run(tmrRun),
		.divider(pullScl ? waveReg[WAVE_LOW_LSB +: 8] :
			waveReg[WAVE_HIGH_LSB +: 8]),
		.exponent(waveReg[WAVE_EXP_LSB +: 3]),
		.done(tmrDone)
	);

	// Setup registers
	always_ff @(posedge clk) begin
		if (rstAll) begin
			modeReg <= MODE_RESET;
			iadrReg <= IADR_RESET;
			waveReg <= WAVE_RESET;
			mask <= IMR_RESET[ST_W-1:0];
		end else if (bus.wr) begin
			if (bus.addr == OFS_MODE) modeReg <= bus.wdata & MODE_MASK;
			if (bus.addr == OFS_IADR) iadrReg <= bus.wdata & IADR_MASK;
			if (bus.addr == OFS_WAVE) waveReg <= bus.wdata & WAVE_MASK;
			if (bus.addr == OFS_IER) mask <= mask | bus.wdata[ST_W-1:0];
			if (bus.addr == OFS_IDR) mask <= mask & ~bus.wdata[ST_W-1:0];
		end
	end

	// Holding register; a write wins over a load or a not-ack flush,
	// and the flush keeps a refused byte from relaunching frames forever
	always_ff @(posedge clk) begin
		if (rstAll) begin
			thr <= THR_RESET;
			thrFull <= 1'b0;
		end else if (thrWr) begin
			thr <= bus.wdata[7:0];
			thrFull <= 1'b1;
		end else if (goTx || nackEv) begin
			thrFull <= 1'b0;
		end
	end

	// disable only once idle and drained
	always_ff @(posedge clk) begin
		if (rstAll) begin
			master_enable_cmd <= 1'b0;
			disablePend <= 1'b0;
		end else if (msenEv) begin
			master_enable_cmd <= 1'b1;
			disablePend <= 1'b0;
		end else if (cmdWr && bus.wdata[CMD_MASTER_DISABLE_CMD]) begin
			disablePend <= 1'b1;
		end else if (disablePend && state == S_IDLE && !thrFull && !go) begin
			master_enable_cmd <= 1'b0;
			disablePend <= 1'b0;
		end
	end

	// holding write launches a write frame
	assign go = state == S_IDLE && master_enable_cmd &&
		((cmdWr && bus.wdata[CMD_START]) || (!rdDir && (thrWr || thrFull)));

	// stop request, set wins over clear
	always_ff @(posedge clk) begin
		if (rstAll) begin
			stopReq <= 1'b0;
		end else if (cmdWr && bus.wdata[CMD_STOP]) begin
			stopReq <= 1'b1;
		end else if (stopDone || (state == S_IDLE && !go)) begin
			stopReq <= 1'b0;
		end
	end

	// Byte and slot events
	assign bitEnd = state == S_BITS && hi && tmrDone;
	assign ackEnd = bitEnd && bitCnt == ACK_SLOT;
	// slave ack is a low level in the slot
	assign nackEv = ackEnd && kind != K_RX && sdaSync;
	assign rxLand = bitEnd && bitCnt == 4'h7 && kind == K_RX;
	assign stopDone = state == S_STOP && step == 2'h2 && tmrDone;
	assign nextIdx = (kind == K_DEV) ? asz - 2'h1 : idx - 2'h1;

	// What follows the acknowledge slot
	always_comb begin
		goStop = 1'b0;
		goRestart = 1'b0;
		goIad = 1'b0;
		goTx = 1'b0;
		goRx = 1'b0;
		if (ackEnd) begin
			case (kind)
				K_DEV: begin
					if (sdaSync) goStop = 1'b1;
					else if (rdDir && (asz == 2'h0 || restarted)) goRx = 1'b1;
					else if (asz != 2'h0 && !restarted) goIad = 1'b1;
					else goTx = 1'b1;
				end
				K_IAD: begin
					if (sdaSync) goStop = 1'b1;
					else if (idx != 2'h0) goIad = 1'b1;
					else if (rdDir) goRestart = 1'b1;
					else goTx = 1'b1;
				end
				K_TX: begin
					if (sdaSync || stopReq) goStop = 1'b1;
					else goTx = 1'b1;
				end
				K_RX: begin
					if (stopReq) goStop = 1'b1;
					else goRx = 1'b1;
				end
				default: goStop = 1'b1;
			endcase
			if (goTx && !thrFull) begin
				goTx = 1'b0;
				goStop = 1'b1;
			end
		end
	end

	// Sequencer: clock pin and shifter
	always_ff @(posedge clk) begin
		if (rstAll) begin
			state <= S_IDLE;
			kind <= K_DEV;
			step <= 2'h0;
			hi <= 1'b0;
			bitCnt <= 4'h0;
			shift <= 8'h00;
			idx <= 2'h0;
			restarted <= 1'b0;
			pullScl <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (go) begin
						state <= S_START;
						step <= 2'h0;
					end
				end
				S_START: begin
					if (tmrDone && step == 2'h0) begin
						step <= 2'h1;
					end else if (tmrDone) begin
						state <= S_BITS;
						pullScl <= 1'b1;
						hi <= 1'b0;
						bitCnt <= 4'h0;
						kind <= K_DEV;
						shift <= {device_address_field, restarted || (rdDir && asz == 2'h0)};
					end
				end
				S_BITS: begin
					if (tmrDone && !hi) begin
						hi <= 1'b1;
						pullScl <= 1'b0;
					end else if (tmrDone) begin
						hi <= 1'b0;
						pullScl <= 1'b1;
						// eight bits then the ack slot
						if (bitCnt != ACK_SLOT) begin
							shift <= {shift[6:0], sdaSync};
							bitCnt <= bitCnt + 4'h1;
						end else begin
							bitCnt <= 4'h0;
							if (goStop) begin
								state <= S_STOP;
								step <= 2'h0;
							end
							if (goRestart) begin
								state <= S_RELEASE;
								restarted <= 1'b1;
							end
							if (goIad) begin
								kind <= K_IAD;
								idx <= nextIdx;
								shift <= iadrReg[8 * nextIdx +: 8];
							end
							if (goTx) begin
								kind <= K_TX;
								shift <= thr;
							end
							if (goRx) kind <= K_RX;
						end
					end
				end
				S_RELEASE: begin
					// Repeated start: release clock with data high
					if (tmrDone) begin
						pullScl <= 1'b0;
						state <= S_START;
						step <= 2'h0;
					end
				end
				S_STOP: begin
					if (tmrDone && step == 2'h0) begin
						pullScl <= 1'b0;
						step <= 2'h1;
					end else if (tmrDone && step == 2'h1) begin
						step <= 2'h2;
					end else if (tmrDone) begin
						state <= S_IDLE;
						restarted <= 1'b0;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// release the line in the ack slot of sent bytes
	// master answers not-ack once stop is requested
	assign bitPull = (bitCnt == ACK_SLOT) ? (kind == K_RX && !stopReq) :
		(kind != K_RX && !shift[7]);

	// Data pin lags clock moves by one cycle so edges never coincide
	always_ff @(posedge clk) begin
		if (rstAll) begin
			pullSda <= 1'b0;
		end else begin
			case (state)
				S_START: pullSda <= step == 2'h1;
				// update only in the low phase
				S_BITS: if (!hi) pullSda <= bitPull;
				S_STOP: pullSda <= step != 2'h2;
				default: pullSda <= 1'b0;
			endcase
		end
	end

	// open drain: drive low or let go
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe_n = !pullScl;
	assign sdaOe_n = !pullSda;

	// Status flags; hardware set wins over software clear
	always_ff @(posedge clk) begin
		if (rstAll) begin
			txComp <= STATUS_RESET[ST_TXCOMP];
			transmit_ready_flag <= STATUS_RESET[ST_TRANSMIT_READY_FLAG];
			receive_ready_flag <= STATUS_RESET[ST_RECEIVE_READY_FLAG];
			ovre <= STATUS_RESET[ST_OVRE];
			not_ack_status <= STATUS_RESET[ST_NOT_ACK_STATUS];
			rhr <= RHR_RESET;
		end else begin
			if (stopDone || msenEv) txComp <= 1'b1;
			else if (go) txComp <= 1'b0;
			// set on load, fault or enable, held until next write
			if (goTx || nackEv || msenEv) transmit_ready_flag <= 1'b1;
			else if (thrWr) transmit_ready_flag <= 1'b0;
			// receive flag set on landing, cleared by read
			if (rxLand) receive_ready_flag <= 1'b1;
			else if (rhrRd) receive_ready_flag <= 1'b0;
			if (rxLand && receive_ready_flag) ovre <= 1'b1;
			else if (srRd && txComp) ovre <= 1'b0;
			// not-ack flag, cleared by status read
			if (nackEv) not_ack_status <= 1'b1;
			else if (srRd) not_ack_status <= 1'b0;
			if (rxLand) rhr <= {shift[6:0], sdaSync};
		end
	end

	always_comb begin
		statusVec = '0;
		statusVec[ST_TXCOMP] = txComp;
		statusVec[ST_RECEIVE_READY_FLAG] = receive_ready_flag;
		statusVec[ST_TRANSMIT_READY_FLAG] = transmit_ready_flag;
		statusVec[ST_OVRE] = ovre;
		statusVec[ST_UNRE] = 1'b0;
		statusVec[ST_NOT_ACK_STATUS] = not_ack_status;
	end

	// only enabled flags reach the interrupt
	always_ff @(posedge clk) begin
		if (rstAll) irq <= 1'b0;
		else irq <= |(statusVec & mask);
	end

	// Read data in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk) begin
		if (rstAll) begin
			rdata <= 32'h0000_0000;
		end else if (bus.rd) begin
			case (bus.addr)
				OFS_MODE: rdata <= modeReg;
				OFS_IADR: rdata <= iadrReg;
				OFS_WAVE: rdata <= waveReg;
				OFS_STATUS: rdata <= {23'h000000, statusVec};
				OFS_IMR: rdata <= {23'h000000, mask};
				OFS_RHR: rdata <= {24'h000000, rhr};
				OFS_THR: rdata <= {24'h000000, thr};
				default: rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rstAll);

	a_start_shape: assert property (
		$rose(pullSda) && !pullScl && !$past(pullScl) |->
		$past(state) == S_START) else $error("data fell outside START");
	a_stop_shape: assert property (
		$fell(pullSda) && !pullScl && !$past(pullScl) |->
		$past(state) == S_STOP && $past(step) == 2'h2)
		else $error("data rose outside STOP");
	a_frame_open: assert property (
		state == S_IDLE && go |=> state == S_START && !pullSda && !pullScl)
		else $error("frame did not open with START");
	a_frame_close: assert property (
		stopDone |=> state == S_IDLE && !pullSda && !pullScl && txComp)
		else $error("frame did not close cleanly");
	a_byte_len: assert property (
		rxLand |=> bitCnt == ACK_SLOT && hi == 1'b0)
		else $error("byte not eight bits long");
	a_addr_dir: assert property (
		$past(state) == S_START && state == S_BITS |->
		shift == {device_address_field, restarted || (rdDir && asz == 2'h0)})
		else $error("wrong address byte");
	a_ack_release: assert property (
		state == S_BITS && hi && bitCnt == ACK_SLOT && kind != K_RX |->
		!pullSda) else $error("data held in ack slot");
	a_not_ack_status_stop: assert property (
		nackEv |=> not_ack_status && state == S_STOP && transmit_ready_flag)
		else $error("not-ack did not stop");
	a_irq_gate: assert property (
		(statusVec & mask) == '0 |=> !irq)
		else $error("masked flag raised interrupt");
	a_thr_launch: assert property (
		state == S_IDLE && master_enable_cmd && thrWr && !rdDir |=> state == S_START)
		else $error("holding write did not launch");
	a_transmit_ready_flag_hold: assert property (
		transmit_ready_flag && !thrWr |=> transmit_ready_flag) else $error("transmit ready dropped");
	a_receive_ready_flag_clear: assert property (
		rhrRd && !rxLand |=> !receive_ready_flag) else $error("receive ready stuck");
	a_stop_cmd: assert property (
		ackEnd && stopReq && (kind == K_TX || kind == K_RX) |=>
		state == S_STOP) else $error("stop command ignored");
	a_auto_stop: assert property (
		ackEnd && kind == K_TX && !thrFull |=> state == S_STOP)
		else $error("no STOP with empty holding");
	a_sda_low_only: assert property (
		$changed(pullSda) && !pullScl && !$past(pullScl) |->
		$past(state) inside {S_START, S_STOP})
		else $error("data moved while clock high");
	a_enable_cmd: assert property (
		msenEv |=> master_enable_cmd && transmit_ready_flag && txComp) else $error("enable failed");
	a_disable_wait: assert property (
		master_enable_cmd && state != S_IDLE |=> master_enable_cmd) else $error("disabled mid-frame");
	a_soft_reset: assert property (
		disable iff (!reset_n) swrstPulse |=>
		state == S_IDLE && !master_enable_cmd && !not_ack_status && !pullScl)
		else $error("software reset incomplete");

	c_restart: cover property (goRestart);
	c_multi_write: cover property (ackEnd && kind == K_TX && goTx);
	c_not_ack_status: cover property (nackEv);
	c_last_read: cover property (rxLand && stopReq);
endmodule : two_wire_bus_master
`default_nettype wire

/* bench/twi_slave_model.sv */
// Purpose: behavioural two-wire slave that logs bytes and answers reads
// Assumes: lines arrive as resolved wired-AND levels with pull-ups
// Notes: it never stretches the clock; outside its own slots it lets go
`timescale 1ns/1ps
`default_nettype none
module twi_slave_model #(
	parameter logic [7:0] READ_BYTE = 8'hA5
) (
	// Resolved lines
	input wire logic scl,
	input wire logic sda,
	// Test control: refuse every byte
	input wire logic nackAll,
	// Open-drain data, low pulls the line
	output logic sdaRel
);
	logic [7:0] shiftIn;
	logic [7:0] got[$];
	int bitCnt = 0;
	int stops = 0;
	logic first = 1'b0;
	logic reading = 1'b0;
	logic sending;

	assign sending = reading && !first;
	initial sdaRel = 1'b1;
	// START restarts the byte count, STOP is only counted
	always @(negedge sda) if (scl === 1'b1) begin
		bitCnt = 0;
		first = 1'b1;
		reading = 1'b0;
	end
	always @(posedge sda) if (scl === 1'b1) stops++;
	always @(posedge scl) begin
		if (bitCnt < 8) begin
			shiftIn = {shiftIn[6:0], sda};
			bitCnt++;
			if (bitCnt == 8 && !sending) got.push_back(shiftIn);
			if (bitCnt == 8 && first) reading = shiftIn[0];
		end else begin
			// A refused read byte means the master wants the line back
			if (sending && sda) reading = 1'b0;
			bitCnt = 0;
			first = 1'b0;
		end
	end
	// Pull low to ack, change data only while clock low
	always @(negedge scl) begin
		if (bitCnt == 8) sdaRel = sending ? 1'b1 : nackAll;
		else if (sending) sdaRel = READ_BYTE[7 - bitCnt];
		else sdaRel = 1'b1;
	end
endmodule : twi_slave_model
`default_nettype wire

/* bench/two_wire_bus_master_tb_top.sv */
// Purpose: self-checking bench for the two-wire bus master
// Assumes: pull-ups on both lines, slave never stretches the clock
// Notes: waveform 0x10102 gives 7-cycle low and 5-cycle high phases
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_master_tb_top
	import twi_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	bus_req_t bus = '0;
	logic [31:0] rdata;
	logic irq, sclOut, sclOe_n, sdaOut, sdaOe_n, sdaRel, scl, sda;
	logic nackAll = 1'b0;
	logic prevScl = 1'b1;
	int nMismatch = 0, checked = 0, run = 0, lastLow = 0, lastHigh = 0;
	int s;
	logic [31:0] v;

	always #20 clk = ~clk;
	// Wired-AND with pull-ups; enables are active low
	assign scl = sclOe_n | sclOut;
	assign sda = (sdaOe_n | sdaOut) & sdaRel;
	// Length of the last low and high clock runs in clk cycles
	always @(posedge clk) begin
		if (sclOe_n === prevScl) run++;
		else begin
			if (prevScl === 1'b0) lastLow = run;
			else lastHigh = run;
			run = 1;
		end
		prevScl = sclOe_n;
	end

	two_wire_bus_master i_two_wire_bus_master (
		.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.irq(irq), .sclIn(scl), .sclOut(sclOut), .sclOe_n(sclOe_n),
		.sdaIn(sda), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));
	twi_slave_model i_twi_slave_model (
		.scl(scl), .sda(sda), .nackAll(nackAll), .sdaRel(sdaRel));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask : rd
	task automatic mark();
		s = i_twi_slave_model.stops;
		i_twi_slave_model.got.delete();
	endtask : mark
	function automatic logic [7:0] gotAt(input int k);
		return i_twi_slave_model.got[k];
	endfunction : gotAt
	task automatic wait_stop();
		for (int k = 0; k < 4000 && i_twi_slave_model.stops <= s; k++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		check(i_twi_slave_model.stops, s + 1);
	endtask : wait_stop

	task automatic t_reset();
		logic [7:0] a[8];
		a = '{OFS_MODE, OFS_IADR, OFS_WAVE, OFS_STATUS, OFS_IMR,
			OFS_RHR, OFS_CMD, 8'h08};
		foreach (a[i]) begin
			rd(a[i], v);
			check(v, 32'h0);
		end
		wr(OFS_MODE, 32'hFFFF_FFFF);
		rd(OFS_MODE, v);
		check(v, MODE_MASK);
		wr(OFS_STATUS, 32'hFFFF_FFFF);
		rd(OFS_STATUS, v);
		check(v, 32'h0);
	endtask : t_reset
	task automatic t_write();
		mark();
		// size field set for two extra bytes
		wr(OFS_MODE, 32'h0050_0200);
		wr(OFS_IADR, 32'h0012_3456);
		wr(OFS_THR, 32'h96);
		wait_stop();
		check(i_twi_slave_model.got.size(), 4);
		check(gotAt(0), 8'hA0);
		check(gotAt(1), 8'h34);
		check(gotAt(2), 8'h56);
		check(gotAt(3), 8'h96);
		rd(OFS_STATUS, v);
		check(v & 32'h7, 32'h5);
		check(lastLow, 7);
		check(lastHigh, 5);
	endtask : t_write
	task automatic t_read();
		mark();
		wr(OFS_MODE, 32'h0050_1000);
		// single byte: start and stop together
		wr(OFS_CMD, 32'h3);
		wait_stop();
		check(gotAt(0), 8'hA1);
		rd(OFS_STATUS, v);
		check(v[ST_RECEIVE_READY_FLAG], 1'b1);
		rd(OFS_RHR, v);
		check(v, 32'hA5);
		rd(OFS_STATUS, v);
		check(v[ST_RECEIVE_READY_FLAG], 1'b0);
	endtask : t_read
	// Read through one address byte and a repeated start, two bytes
	task automatic t_restart();
		mark();
		v = '0;
		wr(OFS_MODE, 32'h0050_1100);
		wr(OFS_IADR, 32'h0000_0077);
		wr(OFS_CMD, 32'h1);
		for (int k = 0; k < 400 && !v[ST_RECEIVE_READY_FLAG]; k++) begin
			rd(OFS_STATUS, v);
		end
		check(v[ST_RECEIVE_READY_FLAG], 1'b1);
		rd(OFS_RHR, v);
		check(v, 32'hA5);
		// Wait past the first ack slot, else that byte gets refused
		repeat (20) @(posedge clk);
		wr(OFS_CMD, 32'h2);
		wait_stop();
		rd(OFS_RHR, v);
		check(v, 32'hA5);
		check(i_twi_slave_model.got.size(), 3);
		check(gotAt(0), 8'hA0);
		check(gotAt(1), 8'h77);
		check(gotAt(2), 8'hA1);
	endtask : t_restart
	task automatic t_not_ack_status();
		mark();
		nackAll = 1'b1;
		wr(OFS_IER, 32'h100);
		rd(OFS_IMR, v);
		check(v, 32'h100);
		check(irq, 1'b0);
		wr(OFS_MODE, 32'h0050_0000);
		wr(OFS_THR, 32'h11);
		wait_stop();
		check(i_twi_slave_model.got.size(), 1);
		check(irq, 1'b1);
		rd(OFS_STATUS, v);
		check(v[ST_NOT_ACK_STATUS], 1'b1);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		wr(OFS_IDR, 32'h100);
		rd(OFS_IMR, v);
		check(v, 32'h0);
		nackAll = 1'b0;
	endtask : t_not_ack_status
	task automatic t_disable();
		mark();
		wr(OFS_CMD, 32'h8);
		wr(OFS_CMD, 32'hC);
		wr(OFS_THR, 32'h22);
		repeat (300) @(posedge clk);
		check(i_twi_slave_model.stops, s);
		wr(OFS_CMD, 32'h4);
		wait_stop();
		check(gotAt(1), 8'h22);
	endtask : t_disable
	task automatic t_swreset();
		wr(OFS_CMD, 32'h80);
		repeat (3) @(posedge clk);
		rd(OFS_MODE, v);
		check(v, MODE_RESET);
		rd(OFS_WAVE, v);
		check(v, WAVE_RESET);
	endtask : t_swreset

	task automatic report_and_stop();
		if (nMismatch == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		wr(OFS_WAVE, 32'h0001_0102);
		wr(OFS_CMD, 32'h4);
		t_write();
		t_read();
		t_restart();
		t_not_ack_status();
		t_disable();
		t_swreset();
		report_and_stop();
	end
	// Watchdog, far beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		report_and_stop();
	end
endmodule : two_wire_bus_master_tb_top
`default_nettype wire
